// [gpio_port_with_pin_steering.sv]
`include "gpio_port_regs.svh"

module gpio_port_with_pin_steering
    import gpio_pkg::*;
(
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // AXI4-Lite write address
    input  wire logic [31:0] s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [31:0] s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Pins
    input  wire pin_vec_t    pin_i,
    output pin_vec_t         pin_o,
    output pin_vec_t         pin_oe,
    output pin_vec_t         pullup_en,
    output pin_vec_t         input_buf_dis,
    // Peripheral functions, bit order as the steering control
    input  wire func_vec_t   func_en,
    input  wire func_vec_t   func_out,
    input  wire func_vec_t   func_drive,
    output func_vec_t        func_in
);

    ////////////////////////////////////////////////////////////////////////////
    // Register state

    port_byte_t [2:0] dir_q;
    port_byte_t [2:0] latch_q;
    port_byte_t [2:0] analog_q;
    port_byte_t [2:0] pullup_q;
    func_vec_t        steer_q;

    pin_vec_t         pin_sync_q;
    pin_vec_t         pin_level;
    pin_vec_t         dir_flat;
    pin_vec_t         latch_flat;
    pin_vec_t         analog_flat;
    pin_vec_t         pullup_flat;
    pin_vec_t         pin_o_d;
    pin_vec_t         pin_oe_d;
    pin_vec_t         pullup_en_d;
    pin_vec_t         pin_o_q;
    pin_vec_t         pin_oe_q;
    pin_vec_t         pullup_en_q;
    func_vec_t        func_in_d;
    func_vec_t        func_in_q;

    pin_ovr_if        ovr ();

    ////////////////////////////////////////////////////////////////////////////
    // Pin input path

    pin_sync u_sync (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .pin_async  (pin_i),
        .pin_sync_q (pin_sync_q)
    );

    assign dir_flat    = {dir_q[2], dir_q[1], dir_q[0]};
    assign latch_flat  = {latch_q[2], latch_q[1], latch_q[0]};
    assign analog_flat = {analog_q[2], analog_q[1], analog_q[0]};
    assign pullup_flat = {pullup_q[2], pullup_q[1], pullup_q[0]};

    // Buffer off keeps mid-rail analog levels out of the logic; the pin reads 0
    assign pin_level = pin_sync_q & ~analog_flat;

    ////////////////////////////////////////////////////////////////////////////
    // Steering of peripheral functions

    pin_steer u_steer (
        .steer_sel  (steer_q),
        .func_en    (func_en),
        .func_out   (func_out),
        .func_drive (func_drive),
        .pin_level  (pin_level),
        .func_in    (func_in_d),
        .ovr        (ovr.steer)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Pin output path

    always_comb begin
        for (int p = 0; p < 24; p++) begin
            if (ovr.ovr_en[p]) begin
                pin_o_d[p]  = ovr.ovr_dat[p];
                pin_oe_d[p] = ovr.ovr_drv[p];
            end else begin
                pin_o_d[p]  = latch_flat[p];
                pin_oe_d[p] = ~dir_flat[p];
            end
        end
    end

    assign input_buf_dis = analog_flat;
    // Pull-up only while the pin is not being driven
    assign pullup_en_d   = pullup_flat & ~pin_oe_d;

    // Pad controls except input_buf_dis leave through flip-flops: one cycle later, but glitch free
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o_q  <= 24'h000000;
            pin_oe_q <= 24'h000000;
        end else begin
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pullup_en_q <= 24'h000000;
        end else begin
            pullup_en_q <= pullup_en_d;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            func_in_q <= 8'h00;
        end else begin
            func_in_q <= func_in_d;
        end
    end

    assign pin_o     = pin_o_q;
    assign pin_oe    = pin_oe_q;
    assign pullup_en = pullup_en_q;
    assign func_in   = func_in_q;

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    logic        aw_held_q;
    logic        w_held_q;
    logic [6:0]  waddr_q;
    logic [31:0] wdata_q;
    logic [3:0]  wstrb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        wr_fire;
    reg_sel_t    wr_sel;
    logic [1:0]  wr_port;

    assign s_axi_awready = !aw_held_q && !bvalid_q;
    assign s_axi_wready  = !w_held_q && !bvalid_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign wr_fire       = aw_held_q && w_held_q;

    function automatic reg_sel_t decode(input logic [6:0] a);
        reg_sel_t s;
        s = REG_NONE;
        if (a[1:0] == 2'h0) begin
            if (a == 7'(`OFS_PIN_STEERING)) begin
                s = REG_STEERING;
            end else if (a[6:5] != 2'h3) begin
                unique case (5'(a[4:0]))
                    5'(`OFS_PIN_DIRECTION): s = REG_DIRECTION;
                    5'(`OFS_PIN_LEVEL):     s = REG_LEVEL;
                    5'(`OFS_OUTPUT_LATCH):  s = REG_LATCH;
                    5'(`OFS_ANALOG_SELECT): s = REG_ANALOG;
                    5'(`OFS_WEAK_PULLUP):   s = REG_PULLUP;
                    default:                s = REG_NONE;
                endcase
            end
        end
        return s;
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            waddr_q   <= 7'h00;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_q <= 1'b1;
            waddr_q   <= s_axi_awaddr[`ADDR_MSB:0];
        end else if (wr_fire) begin
            aw_held_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_q <= 1'b0;
            wdata_q  <= 32'h00000000;
            wstrb_q  <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_q <= 1'b1;
            wdata_q  <= s_axi_wdata;
            wstrb_q  <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_q <= 1'b0;
        end
    end

    assign wr_sel  = decode(waddr_q);
    assign wr_port = waddr_q[6:5];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= `RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q  <= (wr_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Port registers, one set per port

    logic wr_byte;
    assign wr_byte = wr_fire && wstrb_q[0];

    for (genvar g = 0; g < 3; g++) begin : g_port
        logic hit;
        assign hit = wr_byte && (wr_port == 2'(g));

        // Steering writes decode elsewhere and never reach this register
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                dir_q[g] <= `RST_PIN_DIRECTION;
            end else if (hit && wr_sel == REG_DIRECTION) begin
                dir_q[g] <= wdata_q[7:0];
            end
        end

        // Level and latch writes alike load the byte lane straight into the latch; the pins are not read
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                latch_q[g] <= `RST_OUTPUT_LATCH;
            end else if (hit && (wr_sel == REG_LEVEL || wr_sel == REG_LATCH)) begin
                latch_q[g] <= wdata_q[7:0];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                analog_q[g] <= `RST_ANALOG_SELECT;
            end else if (hit && wr_sel == REG_ANALOG) begin
                analog_q[g] <= wdata_q[7:0];
            end
        end

        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                pullup_q[g] <= `RST_WEAK_PULLUP;
            end else if (hit && wr_sel == REG_PULLUP) begin
                pullup_q[g] <= wdata_q[7:0];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            steer_q <= `RST_PIN_STEERING;
        end else if (wr_byte && wr_sel == REG_STEERING) begin
            steer_q <= wdata_q[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;
    reg_sel_t    rd_sel;
    logic [1:0]  rd_port;
    port_byte_t  rd_byte;
    pin_vec_t    level_bytes;

    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign rd_sel        = decode(s_axi_araddr[`ADDR_MSB:0]);
    assign rd_port       = (s_axi_araddr[6:5] == 2'h3) ? 2'h0 : s_axi_araddr[6:5];
    assign level_bytes   = pin_level;

    always_comb begin
        rd_byte = 8'h00;
        unique case (rd_sel)
            REG_DIRECTION: rd_byte = dir_q[rd_port];
            REG_LEVEL:     rd_byte = level_bytes[8*rd_port +: 8];
            REG_LATCH:     rd_byte = latch_q[rd_port];
            REG_ANALOG:    rd_byte = analog_q[rd_port];
            REG_PULLUP:    rd_byte = pullup_q[rd_port];
            REG_STEERING:  rd_byte = steer_q;
            REG_NONE:      rd_byte = 8'h00;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h00000000;
            rresp_q  <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_q <= 1'b1;
            rdata_q  <= {24'h000000, rd_byte};
            rresp_q  <= (rd_sel == REG_NONE) ? `RESP_SLVERR : `RESP_OKAY;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

endmodule

// [gpio_port_regs.svh]
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// Byte address layout: bits [6:5] pick the port block, bits [4:2] the register
`define PORT_STRIDE        8'h20
`define OFS_PIN_DIRECTION  8'h00
`define OFS_PIN_LEVEL      8'h04
`define OFS_OUTPUT_LATCH   8'h08
`define OFS_ANALOG_SELECT  8'h0C
`define OFS_WEAK_PULLUP    8'h10
`define OFS_PIN_STEERING   8'h60
`define ADDR_MSB           6

// Reset values
`define RST_PIN_DIRECTION  8'hFF
`define RST_OUTPUT_LATCH   8'h00
`define RST_ANALOG_SELECT  8'hFF
`define RST_WEAK_PULLUP    8'h00
`define RST_PIN_STEERING   8'h00

// Steering control bit positions
`define SEL_CMP2_OUT       7
`define SEL_CC1            6
`define SEL_SDO            5
`define SEL_SCK            4
`define SEL_SDI            3
`define SEL_TX             2
`define SEL_RX             1
`define SEL_CC2            0

// Pin indices: port A 0..7, port B 8..15, port C 16..23
`define PIN_CMP2_DEF       5'd5
`define PIN_CMP2_ALT       5'd6
`define PIN_CC1_DEF        5'd18
`define PIN_CC1_ALT        5'd8
`define PIN_SDO_DEF        5'd21
`define PIN_SDO_ALT        5'd13
`define PIN_SCK_DEF        5'd19
`define PIN_SCK_ALT        5'd15
`define PIN_SDI_DEF        5'd20
`define PIN_SDI_ALT        5'd14
`define PIN_TX_DEF         5'd22
`define PIN_TX_ALT         5'd14
`define PIN_RX_DEF         5'd23
`define PIN_RX_ALT         5'd15
`define PIN_CC2_DEF        5'd17
`define PIN_CC2_ALT        5'd11

// AXI responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [gpio_pkg.sv]
package gpio_pkg;
    typedef logic [23:0] pin_vec_t;
    typedef logic [7:0]  func_vec_t;
    typedef logic [7:0]  port_byte_t;
    typedef logic [4:0]  pin_idx_t;

    typedef enum logic [2:0] {
        REG_DIRECTION = 3'b000,
        REG_LEVEL     = 3'b001,
        REG_LATCH     = 3'b010,
        REG_ANALOG    = 3'b011,
        REG_PULLUP    = 3'b100,
        REG_STEERING  = 3'b101,
        REG_NONE      = 3'b110
    } reg_sel_t;
endpackage

// [pin_ovr_if.sv]
interface pin_ovr_if;
    import gpio_pkg::*;
    pin_vec_t ovr_en;
    pin_vec_t ovr_dat;
    pin_vec_t ovr_drv;

    modport steer (output ovr_en, output ovr_dat, output ovr_drv);
    modport port  (input ovr_en, input ovr_dat, input ovr_drv);
endinterface

// [pin_sync.sv]
module pin_sync
    import gpio_pkg::*;
(
    input  wire logic     aclk,
    input  wire logic     aresetn,
    input  wire pin_vec_t pin_async,
    output pin_vec_t      pin_sync_q
);
    pin_vec_t meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            meta_q     <= 24'h000000;
            pin_sync_q <= 24'h000000;
        end else begin
            meta_q     <= pin_async;
            pin_sync_q <= meta_q;
        end
    end
endmodule

// [pin_steer.sv]
`include "gpio_port_regs.svh"

module pin_steer
    import gpio_pkg::*;
(
    input  wire func_vec_t steer_sel,
    input  wire func_vec_t func_en,
    input  wire func_vec_t func_out,
    input  wire func_vec_t func_drive,
    input  wire pin_vec_t  pin_level,
    output func_vec_t      func_in,
    pin_ovr_if.steer       ovr
);
    function automatic pin_idx_t pin_of(input int f, input logic alt);
        pin_idx_t idx;
        idx = 5'd0;
        case (f)
            `SEL_CMP2_OUT: idx = alt ? `PIN_CMP2_ALT : `PIN_CMP2_DEF;
            `SEL_CC1:      idx = alt ? `PIN_CC1_ALT  : `PIN_CC1_DEF;
            `SEL_SDO:      idx = alt ? `PIN_SDO_ALT  : `PIN_SDO_DEF;
            `SEL_SCK:      idx = alt ? `PIN_SCK_ALT  : `PIN_SCK_DEF;
            `SEL_SDI:      idx = alt ? `PIN_SDI_ALT  : `PIN_SDI_DEF;
            `SEL_TX:       idx = alt ? `PIN_TX_ALT   : `PIN_TX_DEF;
            `SEL_RX:       idx = alt ? `PIN_RX_ALT   : `PIN_RX_DEF;
            default:       idx = alt ? `PIN_CC2_ALT  : `PIN_CC2_DEF;
        endcase
        return idx;
    endfunction

    pin_vec_t en_v  [8:0];
    pin_vec_t dat_v [8:0];
    pin_vec_t drv_v [8:0];

    assign en_v[0]  = 24'h000000;
    assign dat_v[0] = 24'h000000;
    assign drv_v[0] = 24'h000000;

    // Each function lands on its selected pin only; the other pin is untouched
    for (genvar f = 0; f < 8; f++) begin : g_func
        pin_idx_t sel_pin;
        pin_vec_t hit;
        assign sel_pin = pin_of(f, steer_sel[f]);
        assign hit     = func_en[f] ? (24'h000001 << sel_pin) : 24'h000000;
        assign en_v[f+1]  = en_v[f] | hit;
        assign dat_v[f+1] = dat_v[f] | (func_out[f] ? hit : 24'h000000);
        assign drv_v[f+1] = drv_v[f] | (func_drive[f] ? hit : 24'h000000);
        assign func_in[f] = pin_level[sel_pin];
    end

    // No function wins on a shared pin: enable, data and drive are ORed; software avoids overlaps
    assign ovr.ovr_en  = en_v[8];
    assign ovr.ovr_dat = dat_v[8];
    assign ovr.ovr_drv = drv_v[8];
endmodule

// [gpio_port_checker.sv]
`include "gpio_port_regs.svh"
module gpio_port_checker
    import gpio_pkg::*;
(
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire pin_vec_t    pin_o,
    input wire pin_vec_t    pin_oe,
    input wire pin_vec_t    pullup_en,
    input wire pin_vec_t    input_buf_dis,
    input wire func_vec_t   func_en,
    input wire func_vec_t   func_out,
    input wire func_vec_t   func_drive,
    input wire func_vec_t   func_in
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    ////////////////////////////////////////////////////////////////////////////////
    a_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    a_b_stands: assert property ($fell(s_axi_bvalid) |-> $past(s_axi_bready))
        else $error("write response dropped early");
    a_r_stands: assert property ($fell(s_axi_rvalid) |-> $past(s_axi_rready))
        else $error("read data dropped early");
    a_w_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while answer pending");
    a_pull_off: assert property ((pullup_en & pin_oe) == '0)
        else $error("pull-up on driven pin");
    a_cc2_route: assert property (func_en[`SEL_CC2] |=>
        (pin_oe[`PIN_CC2_DEF] == $past(func_drive[0]) &&
         pin_o[`PIN_CC2_DEF] == $past(func_out[0])) ||
        (pin_oe[`PIN_CC2_ALT] == $past(func_drive[0]) &&
         pin_o[`PIN_CC2_ALT] == $past(func_out[0])))
        else $error("capture unit not on a pin");
    a_analog_in: assert property (
        input_buf_dis[`PIN_CC2_DEF] && input_buf_dis[`PIN_CC2_ALT] |=> !func_in[`SEL_CC2])
        else $error("analog pin reads high");
    a_reset_state: assert property (
        $past(aresetn) == 1'h0 && func_en == '0 |->
        pin_oe == '0 && input_buf_dis == '1 && pullup_en == '0)
        else $error("pins not at reset state");
endmodule
bind gpio_port_with_pin_steering gpio_port_checker i_gpio_port_checker (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .pin_o(pin_o), .pin_oe(pin_oe), .pullup_en(pullup_en), .input_buf_dis(input_buf_dis),
    .func_en(func_en), .func_out(func_out), .func_drive(func_drive), .func_in(func_in));

// [pin_world.sv]
module pin_world
    import gpio_pkg::*;
(
    input  wire logic     aclk,
    input  wire pin_vec_t pin_o,
    input  wire pin_vec_t pin_oe,
    input  wire pin_vec_t pullup_en,
    input  wire pin_vec_t ext_en,
    input  wire pin_vec_t ext_val,
    output pin_vec_t      pin_i
);
    timeunit 1ns;
    timeprecision 1ps;
    pin_vec_t last_q = '0;
    // A floating pin flips each cycle, so a stale level never passes for a fresh one
    always_ff @(posedge aclk) begin
        last_q <= pin_i;
    end
    always_comb begin
        for (int p = 0; p < 24; p++) begin
            if (pin_oe[p]) pin_i[p] = pin_o[p];
            else if (ext_en[p]) pin_i[p] = ext_val[p];
            else if (pullup_en[p]) pin_i[p] = 1'h1;
            else pin_i[p] = ~last_q[p];
        end
    end
endmodule

// [test_gpio_port_with_pin_steering.sv]
`include "gpio_port_regs.svh"
module test_gpio_port_with_pin_steering
    import gpio_pkg::*;
    ;
    timeunit 1ns;
    timeprecision 1ps;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
    logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    pin_vec_t    pin_i, pin_o, pin_oe, pullup_en, input_buf_dis;
    pin_vec_t    ext_en = '0, ext_val = '0;
    func_vec_t   func_en = '0, func_out = '0, func_drive = '0, func_in;
    int          n_fail = 0, comparisons = 0;
    pin_idx_t    dp[8] = '{`PIN_CC2_DEF, `PIN_RX_DEF, `PIN_TX_DEF, `PIN_SDI_DEF,
                           `PIN_SCK_DEF, `PIN_SDO_DEF, `PIN_CC1_DEF, `PIN_CMP2_DEF};
    pin_idx_t    ap[8] = '{`PIN_CC2_ALT, `PIN_RX_ALT, `PIN_TX_ALT, `PIN_SDI_ALT,
                           `PIN_SCK_ALT, `PIN_SDO_ALT, `PIN_CC1_ALT, `PIN_CMP2_ALT};
    ////////////////////////////////////////////////////////////////////////////////
    gpio_port_with_pin_steering i_gpio_port_with_pin_steering (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .pullup_en(pullup_en), .input_buf_dis(input_buf_dis),
        .func_en(func_en), .func_out(func_out), .func_drive(func_drive), .func_in(func_in));
    pin_world i_pin_world (.aclk(aclk), .pin_o(pin_o), .pin_oe(pin_oe),
        .pullup_en(pullup_en), .ext_en(ext_en), .ext_val(ext_val), .pin_i(pin_i));
    initial begin
        forever #12.5 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Both channels offered together; bready stays up until the answer is seen
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        @(posedge aclk);
        awaddr <= {24'h0, a};
        wdata <= {24'h0, d};
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        bready <= 1'h1;
        repeat (20) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'h0;
            if (wvalid && wready) wvalid <= 1'h0;
            if (bvalid) begin
                bready <= 1'h0;
                chk("bresp", er, bresp);
                return;
            end
        end
        n_fail++;
        final_report();
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [1:0] er);
        @(posedge aclk);
        araddr <= {24'h0, a};
        arvalid <= 1'h1;
        rready <= 1'h1;
        repeat (20) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'h0;
            if (rvalid) begin
                rready <= 1'h0;
                chk("rresp", er, rresp);
                chk("rdata", {24'h0, e}, rdata);
                return;
            end
        end
        n_fail++;
        final_report();
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        func_vec_t  f;
        logic [7:0] b;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        for (int p = 0; p < 3; p++) begin
            b = 8'(p) * `PORT_STRIDE;
            rd(b + `OFS_PIN_DIRECTION, `RST_PIN_DIRECTION, `RESP_OKAY);
            rd(b + `OFS_PIN_LEVEL, 8'h00, `RESP_OKAY);
            rd(b + `OFS_OUTPUT_LATCH, `RST_OUTPUT_LATCH, `RESP_OKAY);
            rd(b + `OFS_ANALOG_SELECT, `RST_ANALOG_SELECT, `RESP_OKAY);
            rd(b + `OFS_WEAK_PULLUP, `RST_WEAK_PULLUP, `RESP_OKAY);
        end
        rd(`OFS_PIN_STEERING, `RST_PIN_STEERING, `RESP_OKAY);
        chk("pin_oe", 32'h0, pin_oe);
        rd(8'h14, 8'h00, `RESP_SLVERR);
        wr(8'h7C, 8'hFF, `RESP_SLVERR);
        $display("test reset done");
        ext_en <= 24'h00000F;
        ext_val <= 24'h000005;
        wr(`OFS_ANALOG_SELECT, 8'h01, `RESP_OKAY);
        chk("input_buf_dis", 32'h01, input_buf_dis[7:0]);
        wr(`OFS_PIN_DIRECTION, 8'h0F, `RESP_OKAY);
        wr(`OFS_OUTPUT_LATCH, 8'hA5, `RESP_OKAY);
        @(posedge aclk);
        chk("pin_o", 32'hA5, pin_o[7:0]);
        chk("pin_oe", 32'hF0, pin_oe[7:0]);
        wr(`OFS_PIN_LEVEL, 8'h3C, `RESP_OKAY);
        rd(`OFS_OUTPUT_LATCH, 8'h3C, `RESP_OKAY);
        rd(`OFS_PIN_LEVEL, 8'h34, `RESP_OKAY);
        wr(`OFS_WEAK_PULLUP, 8'hFF, `RESP_OKAY);
        @(posedge aclk);
        chk("pullup_en", 32'h0F, pullup_en[7:0]);
        wr(`OFS_PIN_DIRECTION, 8'hFF, `RESP_OKAY);
        @(posedge aclk);
        chk("pullup_en", 32'hFF, pullup_en[7:0]);
        $display("test port done");
        for (int i = 0; i < 8; i++) begin
            f = 8'h01 << i;
            func_en <= f;
            func_out <= f;
            func_drive <= f;
            repeat (2) @(posedge aclk);
            chk("default pin", 32'h3, {pin_oe[dp[i]], pin_o[dp[i]]});
            chk("spare pin", 32'h0, pin_oe[ap[i]]);
            wr(`OFS_PIN_STEERING, f, `RESP_OKAY);
            @(posedge aclk);
            chk("alternate pin", 32'h3, {pin_oe[ap[i]], pin_o[ap[i]]});
            chk("released pin", 32'h0, pin_oe[dp[i]]);
            rd({ap[i][4:3], 5'h00}, 8'hFF, `RESP_OKAY);
            chk("func_in", 32'h80, func_in);
            wr(`OFS_PIN_STEERING, 8'h00, `RESP_OKAY);
        end
        func_en <= '0;
        $display("test steering done");
        wr(`OFS_PIN_STEERING, 8'hFF, `RESP_OKAY);
        @(posedge aclk);
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        rd(`OFS_PIN_STEERING, `RST_PIN_STEERING, `RESP_OKAY);
        rd(`OFS_OUTPUT_LATCH, `RST_OUTPUT_LATCH, `RESP_OKAY);
        rd(`OFS_WEAK_PULLUP, `RST_WEAK_PULLUP, `RESP_OKAY);
        $display("test second reset done");
        final_report();
    end
endmodule
